//--- include/xcvr_pkg.sv
package xcvr_pkg;

  localparam int SECTIONS   = 2;
  localparam int LINE_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_RESET = 1;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] STORE0_OFS = 8'h08;
  localparam logic [7:0] STORE1_OFS = 8'h0c;
  localparam logic [7:0] LOG_OFS    = 8'h10;

  // control register
  localparam int          CTRL_LOG_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // status register fields
  localparam int STAT_CTRL_POS   = 0;
  localparam int STAT_SUPPLY_POS = 12;
  localparam int STAT_DRIVE_POS  = 14;
  localparam int STAT_COUNT_POS  = 18;
  localparam int STAT_OVF_BIT    = 22;

  // store and log register fields
  localparam int STORE_BA_POS  = 8;
  localparam int LOG_VALID_BIT = 31;

  typedef struct packed {
    logic outputEnableN;
    logic flowSel;
    logic aCaptureStrobe;
    logic bCaptureStrobe;
    logic aToBSourceSel;
    logic bToASourceSel;
  } sectionCtrl_t;

  typedef struct packed {
    logic [LINE_W-1:0] out;
    logic [LINE_W-1:0] oe;
  } pinDrive_t;

  typedef struct packed {
    logic              section;
    logic              fromB;
    logic [LINE_W-1:0] data;
  } logEntry_t;

  localparam int LOG_W   = $bits(logEntry_t);
  localparam int CTRL_W  = $bits(sectionCtrl_t);
  localparam int RAW_SEC = CTRL_W + 2 * LINE_W;
  localparam int RAW_W   = SECTIONS * RAW_SEC + 2;

endpackage : xcvr_pkg

//--- core/registered_bus_transceiver.sv
`timescale 1ns/1ps
`default_nettype none

module capture_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem_r[rdPtr_r];
  assign count    = count_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : capture_fifo

module registered_bus_transceiver (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire xcvr_pkg::sectionCtrl_t       sectionCtrl  [xcvr_pkg::SECTIONS],
  input  wire logic                         aSupplyOk,
  input  wire logic                         bSupplyOk,
  input  wire logic [xcvr_pkg::LINE_W-1:0]  aSideLineIn  [xcvr_pkg::SECTIONS],
  input  wire logic [xcvr_pkg::LINE_W-1:0]  bSideLineIn  [xcvr_pkg::SECTIONS],
  output xcvr_pkg::pinDrive_t               aSideLineDrv [xcvr_pkg::SECTIONS],
  output xcvr_pkg::pinDrive_t               bSideLineDrv [xcvr_pkg::SECTIONS],
  output logic                              logReady
);
  localparam int NS  = xcvr_pkg::SECTIONS;
  localparam int LW  = xcvr_pkg::LINE_W;
  localparam int RS  = xcvr_pkg::RAW_SEC;
  localparam int RW  = xcvr_pkg::RAW_W;
  localparam int NEV = 2 * NS;
  localparam int CW  = $clog2(xcvr_pkg::FIFO_DEPTH) + 1;

  // pin synchroniser, three stages
  logic [RW-1:0] rawIn;
  logic [RW-1:0] sync1_r;
  logic [RW-1:0] sync2_r;
  logic [RW-1:0] sync3_r;
  logic [RW-1:0] filt_r;

  logic [LW-1:0] abStore_r [NS];
  logic [LW-1:0] baStore_r [NS];
  logic [NEV-1:0] capEvt;
  logic [NEV-1:0] pend_r;
  logic [NEV-1:0] grant;
  logic [NEV-1:0] driveState;
  logic [NS*xcvr_pkg::CTRL_W-1:0] ctrlState;
  logic           supplyBoth;
  logic           logEn_r;
  logic           ovf_r;
  logic           ready_r;
  logic           slverr_r;
  logic [31:0]    rdata_r;
  logic           logReady_r;

  logic                 fifoInReady;
  logic                 fifoOutValid;
  xcvr_pkg::logEntry_t  pushEntry;
  xcvr_pkg::logEntry_t  headEntry;
  logic [CW-1:0]        fifoCount;

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_raw
      assign rawIn[s*RS +: RS] = {sectionCtrl[s], aSideLineIn[s], bSideLineIn[s]};
    end
  endgenerate
  assign rawIn[RW-1 -: 2] = {aSupplyOk, bSupplyOk};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= '1;
      sync2_r <= '1;
      sync3_r <= '1;
      filt_r  <= '1;
    end else begin
      sync1_r <= rawIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
    end
  end

  assign supplyBoth = filt_r[RW-1] & filt_r[RW-2];

  generate
    for (s = 0; s < NS; s++) begin : g_sec
      xcvr_pkg::sectionCtrl_t c;
      logic [LW-1:0] aLine;
      logic [LW-1:0] bLine;
      logic          aPrev_r;
      logic          bPrev_r;
      logic          oeEff;
      logic          driveA;
      logic          driveB;
      logic [LW-1:0] aOutNxt;
      logic [LW-1:0] bOutNxt;
      logic [LW-1:0] aOut_r;
      logic [LW-1:0] bOut_r;
      logic [LW-1:0] aOe_r;
      logic [LW-1:0] bOe_r;

      assign c     = filt_r[s*RS + 2*LW +: xcvr_pkg::CTRL_W];
      assign aLine = filt_r[s*RS + LW +: LW];
      assign bLine = filt_r[s*RS +: LW];

      // strobe edges, independent of enable and direction
      assign capEvt[2*s]   = c.aCaptureStrobe & ~aPrev_r;
      assign capEvt[2*s+1] = c.bCaptureStrobe & ~bPrev_r;

      // no reset on the stores
      always_ff @(posedge clk) begin
        if (capEvt[2*s]) abStore_r[s] <= aLine;
        if (capEvt[2*s+1]) baStore_r[s] <= bLine;
      end

      assign oeEff   = ~c.outputEnableN & supplyBoth;
      assign driveA  = oeEff & ~c.flowSel;
      assign driveB  = oeEff & c.flowSel;
      assign aOutNxt = c.bToASourceSel ? baStore_r[s] : bLine;
      assign bOutNxt = c.aToBSourceSel ? abStore_r[s] : aLine;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          aPrev_r <= 1'b1;
          bPrev_r <= 1'b1;
          aOut_r  <= '0;
          bOut_r  <= '0;
          aOe_r   <= '0;
          bOe_r   <= '0;
        end else begin
          aPrev_r <= c.aCaptureStrobe;
          bPrev_r <= c.bCaptureStrobe;
          aOut_r  <= aOutNxt;
          bOut_r  <= bOutNxt;
          aOe_r   <= {LW{driveA}};
          bOe_r   <= {LW{driveB}};
        end
      end

      assign aSideLineDrv[s] = '{out: aOut_r, oe: aOe_r};
      assign bSideLineDrv[s] = '{out: bOut_r, oe: bOe_r};
      assign driveState[2*s +: 2] = {aOe_r[0], bOe_r[0]};
      assign ctrlState[s*xcvr_pkg::CTRL_W +: xcvr_pkg::CTRL_W] = c;
    end
  endgenerate

  // capture log: lowest pending event goes first
  always_comb begin
    grant = '0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (pend_r[i] && fifoInReady) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  logic [$clog2(NEV)-1:0] grantIdx;
  always_comb begin
    grantIdx = '0;
    for (int i = 0; i < NEV; i++) begin
      if (grant[i]) grantIdx = ($clog2(NEV))'(i);
    end
  end

  assign pushEntry = '{section: grantIdx[1],
                       fromB:   grantIdx[0],
                       data:    grantIdx[0] ? baStore_r[grantIdx[1]] : abStore_r[grantIdx[1]]};

  // apb decode
  logic setup;
  logic access;
  logic wrAccess;
  logic hit;
  logic logPop;
  logic ovfSet;
  logic ovfClr;
  logic [31:0] readWord;
  logic        selCtrl;
  logic        selStatus;
  logic        selStore0;
  logic        selStore1;
  logic        selLog;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;
  logic [31:0] store0Word;
  logic [31:0] store1Word;
  logic [31:0] logWord;

  assign setup    = psel & ~penable;
  assign access   = psel & penable & ready_r;
  assign wrAccess = access & pwrite;
  assign hit      = selCtrl | selStatus | selStore0 | selStore1 | selLog;
  assign logPop   = access & ~pwrite & selLog;
  assign ovfSet   = |(capEvt & pend_r & ~grant);
  assign ovfClr   = wrAccess & (paddr == xcvr_pkg::STATUS_OFS) & pwdata[xcvr_pkg::STAT_OVF_BIT];

  // read word selection
  assign selCtrl    = (paddr == xcvr_pkg::CTRL_OFS);
  assign selStatus  = (paddr == xcvr_pkg::STATUS_OFS);
  assign selStore0  = (paddr == xcvr_pkg::STORE0_OFS);
  assign selStore1  = (paddr == xcvr_pkg::STORE1_OFS);
  assign selLog     = (paddr == xcvr_pkg::LOG_OFS);

  assign ctrlWord   = 32'(logEn_r) << xcvr_pkg::CTRL_LOG_EN_BIT;
  assign statusWord = (32'(ctrlState) << xcvr_pkg::STAT_CTRL_POS) |
                      (32'(filt_r[RW-1 -: 2]) << xcvr_pkg::STAT_SUPPLY_POS) |
                      (32'(driveState) << xcvr_pkg::STAT_DRIVE_POS) |
                      (32'(fifoCount) << xcvr_pkg::STAT_COUNT_POS) |
                      (32'(ovf_r) << xcvr_pkg::STAT_OVF_BIT);
  assign store0Word = 32'(abStore_r[0]) | (32'(baStore_r[0]) << xcvr_pkg::STORE_BA_POS);
  assign store1Word = 32'(abStore_r[1]) | (32'(baStore_r[1]) << xcvr_pkg::STORE_BA_POS);
  assign logWord    = (32'(fifoOutValid) << xcvr_pkg::LOG_VALID_BIT) |
                      (fifoOutValid ? 32'(headEntry) : 32'h0000_0000);
  assign readWord   = ({32{selCtrl}} & ctrlWord) |
                      ({32{selStatus}} & statusWord) |
                      ({32{selStore0}} & store0Word) |
                      ({32{selStore1}} & store1Word) |
                      ({32{selLog}} & logWord);

  // bus response, one cycle after setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_r  <= 1'b0;
      slverr_r <= 1'b0;
      rdata_r  <= '0;
    end else begin
      ready_r  <= setup;
      slverr_r <= setup & ~hit;
      rdata_r  <= setup ? readWord : '0;
    end
  end

  // control and sticky overflow, set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      logEn_r <= xcvr_pkg::CTRL_RESET[xcvr_pkg::CTRL_LOG_EN_BIT];
      ovf_r   <= 1'b0;
    end else begin
      if (wrAccess && selCtrl) logEn_r <= pwdata[xcvr_pkg::CTRL_LOG_EN_BIT];
      if (ovfSet) ovf_r <= 1'b1;
      else if (ovfClr) ovf_r <= 1'b0;
    end
  end

  // pending capture events and log space
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r     <= '0;
      logReady_r <= 1'b0;
    end else begin
      pend_r     <= (pend_r & ~grant) | (capEvt & {NEV{logEn_r}});
      logReady_r <= fifoInReady;
    end
  end

  assign prdata   = rdata_r;
  assign pready   = ready_r;
  assign pslverr  = slverr_r;
  assign logReady = logReady_r;

  capture_fifo #(
    .WIDTH (xcvr_pkg::LOG_W),
    .DEPTH (xcvr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (|grant),
    .inReady  (fifoInReady),
    .inData   (pushEntry),
    .outValid (fifoOutValid),
    .outReady (logPop),
    .outData  (headEntry),
    .count    (fifoCount)
  );

endmodule : registered_bus_transceiver

`default_nettype wire

//--- bench/bus_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module bus_far_end (
  input  wire xcvr_pkg::pinDrive_t aDrv  [2],
  input  wire xcvr_pkg::pinDrive_t bDrv  [2],
  input  wire logic [7:0]          aFar  [2],
  input  wire logic [7:0]          bFar  [2],
  output logic      [7:0]          aLine [2],
  output logic      [7:0]          bLine [2]
);
  // far side lets go of every line the device drives
  for (genvar i = 0; i < 2; i++) begin : gLine
    assign aLine[i] = (aDrv[i].oe & aDrv[i].out) | (~aDrv[i].oe & aFar[i]);
    assign bLine[i] = (bDrv[i].oe & bDrv[i].out) | (~bDrv[i].oe & bFar[i]);
  end
endmodule : bus_far_end
`default_nettype wire

//--- bench/xcvr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_sva (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire xcvr_pkg::sectionCtrl_t sectionCtrl  [2],
  input wire logic                   aSupplyOk,
  input wire logic                   bSupplyOk,
  input wire logic [7:0]             aSideLineIn  [2],
  input wire logic [7:0]             bSideLineIn  [2],
  input wire xcvr_pkg::pinDrive_t    aSideLineDrv [2],
  input wire xcvr_pkg::pinDrive_t    bSideLineDrv [2]
);
  wire logic en0  = !sectionCtrl[0].outputEnableN && aSupplyOk && bSupplyOk;
  wire logic toB  = en0 && sectionCtrl[0].flowSel;
  wire logic toA  = en0 && !sectionCtrl[0].flowSel;
  wire logic stAB = toB && sectionCtrl[0].aToBSourceSel;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence setupAcc;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence capA;
    $rose(sectionCtrl[0].aCaptureStrobe) && stAB ##1 (stAB && $stable(aSideLineIn[0])) [*6];
  endsequence
  chk_oe_off: assert property (
    sectionCtrl[0].outputEnableN [*7] |-> aSideLineDrv[0].oe == 8'h00 && bSideLineDrv[0].oe == 8'h00)
    else $error("drive while disabled");
  chk_no_supply: assert property (
    (!aSupplyOk || !bSupplyOk) [*7] |-> aSideLineDrv[0].oe == 8'h00 && bSideLineDrv[0].oe == 8'h00)
    else $error("drive without supply");
  chk_b_side: assert property (
    toB [*7] |-> bSideLineDrv[0].oe == 8'hff && aSideLineDrv[0].oe == 8'h00)
    else $error("wrong side toward b");
  chk_a_side: assert property (
    toA [*7] |-> aSideLineDrv[0].oe == 8'hff && bSideLineDrv[0].oe == 8'h00)
    else $error("wrong side toward a");
  chk_live_ab: assert property (
    (toB && !sectionCtrl[0].aToBSourceSel && $stable(aSideLineIn[0])) [*7] |-> bSideLineDrv[0].out == aSideLineIn[0])
    else $error("live a to b wrong");
  chk_live_ba: assert property (
    (toA && !sectionCtrl[0].bToASourceSel && $stable(bSideLineIn[0])) [*7] |-> aSideLineDrv[0].out == bSideLineIn[0])
    else $error("live b to a wrong");
  chk_stored_ab: assert property (
    capA |-> bSideLineDrv[0].out == aSideLineIn[0])
    else $error("stored a to b wrong");
  chk_ready_first: assert property (
    setupAcc |-> pready)
    else $error("no ready in access");
  chk_unmapped_err: assert property (
    pready && paddr == 8'h14 |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
endmodule : xcvr_sva
bind registered_bus_transceiver xcvr_sva chkr (.clk, .rstn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .sectionCtrl, .aSupplyOk, .bSupplyOk, .aSideLineIn, .bSideLineIn, .aSideLineDrv, .bSideLineDrv);
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                   clk, rstn, psel, penable, pwrite, pready, pslverr, logReady, aSupplyOk, bSupplyOk, err;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, d;
  logic [7:0]             farA [2], farB [2], aLine [2], bLine [2];
  xcvr_pkg::sectionCtrl_t sectionCtrl [2];
  xcvr_pkg::pinDrive_t    aDrv [2], bDrv [2];
  int                     error_cnt, checked;
  registered_bus_transceiver uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sectionCtrl, .aSupplyOk, .bSupplyOk, .aSideLineIn(aLine), .bSideLineIn(bLine),
    .aSideLineDrv(aDrv), .bSideLineDrv(bDrv), .logReady);
  bus_far_end far (.aDrv, .bDrv, .aFar(farA), .bFar(farB), .aLine, .bLine);
  always #5 clk = ~clk;
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task conclude();
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    d = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 16) begin
      error_cnt++;
      conclude();
    end
  endtask : apb
  task pulse(input logic b);
    if (b) sectionCtrl[0].bCaptureStrobe <= 1'h1;
    else sectionCtrl[0].aCaptureStrobe <= 1'h1;
    w(4);
    {sectionCtrl[0].aCaptureStrobe, sectionCtrl[0].bCaptureStrobe} <= 2'h0;
    w(4);
  endtask : pulse
  initial begin
    clk = 0;
    rstn = 0;
    {psel, penable, pwrite, paddr, pwdata, error_cnt, checked} = '0;
    {aSupplyOk, bSupplyOk} = 2'h3;
    sectionCtrl = '{default: 6'h20};
    farA = '{default: 8'h00};
    farB = '{default: 8'h00};
    w(4);
    rstn <= 1'h1;
    apb(1'h0, xcvr_pkg::CTRL_OFS, '0);
    chk(d, xcvr_pkg::CTRL_RESET);
    apb(1'h0, 8'h14, '0);
    chk(err, 1'h1);
    apb(1'h1, xcvr_pkg::CTRL_OFS, '0);
    sectionCtrl[0] <= 6'h10;
    sectionCtrl[1] <= 6'h00;
    farA[0] <= 8'h5a;
    farB[1] <= 8'ha5;
    w(8);
    chk(bDrv[0], 16'h5aff);
    chk(aDrv[0].oe, 8'h00);
    chk(aDrv[1], 16'ha5ff);
    chk(bDrv[1].oe, 8'h00);
    pulse(1'h0);
    sectionCtrl[0].aToBSourceSel <= 1'h1;
    farA[0] <= 8'h3c;
    w(8);
    chk(bDrv[0].out, 8'h5a);
    sectionCtrl[0].bToASourceSel <= 1'h1;
    w(8);
    chk(bDrv[0], 16'h5aff);
    sectionCtrl[0] <= 6'h00;
    farB[0] <= 8'hc3;
    w(8);
    pulse(1'h1);
    farB[0] <= 8'h96;
    w(8);
    pulse(1'h0);
    apb(1'h0, xcvr_pkg::STORE0_OFS, '0);
    chk(d, 32'h0000_c396);
    sectionCtrl[0].bToASourceSel <= 1'h1;
    w(8);
    chk(aDrv[0], 16'hc3ff);
    sectionCtrl[0].outputEnableN <= 1'h1;
    w(8);
    chk({aDrv[0].oe, bDrv[0].oe}, 16'h0000);
    apb(1'h0, xcvr_pkg::STORE0_OFS, '0);
    chk(d, 32'h0000_c396);
    sectionCtrl[0].outputEnableN <= 1'h0;
    aSupplyOk <= 1'h0;
    w(8);
    chk({aDrv[0].oe, bDrv[0].oe}, 16'h0000);
    aSupplyOk <= 1'h1;
    apb(1'h1, xcvr_pkg::CTRL_OFS, 32'h1);
    sectionCtrl[0] <= 6'h12;
    farA[0] <= 8'hdd;
    w(8);
    repeat (8) pulse(1'h0);
    chk(logReady, 1'h0);
    pulse(1'h0);
    pulse(1'h0);
    apb(1'h0, xcvr_pkg::STATUS_OFS, '0);
    chk(d[21:18], 4'h8);
    chk(d, 32'h0062_7012);
    apb(1'h1, xcvr_pkg::STATUS_OFS, 32'h1 << xcvr_pkg::STAT_OVF_BIT);
    apb(1'h0, xcvr_pkg::STATUS_OFS, '0);
    chk(d, 32'h0022_7012);
    repeat (9) begin
      apb(1'h0, xcvr_pkg::LOG_OFS, '0);
      chk(d, 32'h8000_00dd);
    end
    apb(1'h0, xcvr_pkg::LOG_OFS, '0);
    chk(d[31], 1'h0);
    chk(logReady, 1'h1);
    conclude();
  end
endmodule : tb
`default_nettype wire
